/* File: logic/timer_consts.vh */
// Constants for the dual four-mode timer/counter block
// Overview of operation
// - Timer ticks every clock or every twelve
// - Event pin sampled each clock, fall counts
// - Fall recognised in four clocks, counts on the next
// - Count only when run and gate allow
// - Mode register: timer1 high nibble, timer0 low
// - Source select: clear internal, set event pin
// - Mode field: 13-bit, 16-bit, reload, split
// - Mode 0 uses high byte, five low bits
// - Rollover to zero sets overflow flag
// - Setting run leaves count bytes untouched
// - Mode 1 cascades bytes, no prescaler
// - Mode 2 reloads low from high, flags
// - Timer 1 in mode 3 holds count
// - Split mode: high byte uses timer1 controls
// - Timer 1 still runs as baud source
// - Flags set on overflow, cleared on vector
// - Control bits: flag1 7, run1 6, flag0 5, run0 4
// - Fast select bits 7 and 6 choose clock
// - Auxiliary bit 0 enables timer 0 clock-out
// - Clock-out toggles at timer 0 overflow, 50%
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// ****************************************
// Register indices, byte address is four times
// ****************************************
`define IDX_CTRL       8'h88
`define IDX_MODE       8'h89
`define IDX_LOW0       8'h8a
`define IDX_LOW1       8'h8b
`define IDX_HIGH0      8'h8c
`define IDX_HIGH1      8'h8d
`define IDX_AUX        8'ha6

// ****************************************
// Field positions
// ****************************************
`define CTRL_FLAG1     7
`define CTRL_RUN1      6
`define CTRL_FLAG0     5
`define CTRL_RUN0      4
`define MODE_T1_SHIFT  4
`define NIB_GATE       3
`define NIB_SRC        2
`define NIB_MHI        1
`define NIB_MLO        0
`define AUX_FAST0      7
`define AUX_FAST1      6
`define AUX_CKOE       0

// ****************************************
// Mode codes, reset values, timing
// ****************************************
`define MODE_13BIT     2'b00
`define MODE_16BIT     2'b01
`define MODE_RELOAD    2'b10
`define MODE_SPLIT     2'b11
`define RESET_BYTE     8'h00
`define SLOW_DIVIDE    12

`endif

/* File: logic/pin_filter.v */
// Three-stage synchroniser with agreement filter and fall detect
`timescale 1ns/1ps
module pin_filter (
   // Clock and reset
   input  wire sys_clk,
   input  wire rstn,
   // Pin side
   input  wire pin_in,
   // Filtered result
   output reg  level_r,
   output reg  fall_r
);
   reg s1_r;
   reg s2_r;
   reg s3_r;

   // ****************************************
   // Synchroniser chain and filter
   // ****************************************
   // A level change counts once the second and third stages agree
   always @(posedge sys_clk) begin
      if (!rstn) begin
         s1_r    <= 1'b0;
         s2_r    <= 1'b0;
         s3_r    <= 1'b0;
         level_r <= 1'b0;
         fall_r  <= 1'b0;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            level_r <= s3_r;
         end
         fall_r <= (s2_r == s3_r) && level_r && !s3_r;
      end
   end
endmodule // pin_filter

/* File: logic/prescale_tick.v */
// Divider giving a one-cycle tick every DIVIDE clocks
`timescale 1ns/1ps
module prescale_tick #(
   parameter DIVIDE = 12
) (
   // Clock and reset
   input  wire sys_clk,
   input  wire rstn,
   // Tick out
   output reg  tick_r
);
   reg [7:0] cnt_r;

   // Free-running count, tick on the last state
   always @(posedge sys_clk) begin
      if (!rstn) begin
         cnt_r  <= 8'h00;
         tick_r <= 1'b0;
      end else if (cnt_r == DIVIDE[7:0] - 8'h01) begin
         cnt_r  <= 8'h00;
         tick_r <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 8'h01;
         tick_r <= 1'b0;
      end
   end
endmodule // prescale_tick

/* File: logic/dual_timer_top.v */
// Two 16-bit timer/counters with four modes behind an APB slave
`timescale 1ns/1ps
`include "timer_consts.vh"
module dual_timer_top (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        rstn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Board pins
   input  wire        timer0_event_pin,
   input  wire        timer1_event_pin,
   input  wire        timer0_gate_pin,
   input  wire        timer1_gate_pin,
   // Processor vectoring into the overflow routines
   input  wire        timer0_vector_ack,
   input  wire        timer1_vector_ack,
   // Outputs
   output reg         timer0_clockout_pin,
   output reg         timer0_clockout_oe,
   output reg         timer1_overflow_pulse
);
   // ****************************************
   // Declarations
   // ****************************************
   reg  [7:0]  timer0_count_low_r;
   reg  [7:0]  timer0_count_high_r;
   reg  [7:0]  timer1_count_low_r;
   reg  [7:0]  timer1_count_high_r;
   reg  [7:0]  timer_mode_select_r;
   reg  [7:0]  auxiliary_control_two_r;
   reg         timer0_run_r;
   reg         timer1_run_r;
   reg         timer0_overflow_flag_r;
   reg         timer1_overflow_flag_r;
   wire        ev0_lvl;
   wire        ev1_lvl;
   wire        ev0_fall;
   wire        ev1_fall;
   wire        gate0_lvl;
   wire        gate1_lvl;
   wire        gate0_fall;
   wire        gate1_fall;
   wire        slow_tick;
   wire [3:0]  nib0;
   wire [3:0]  nib1;
   wire [1:0]  mode0;
   wire [1:0]  mode1;
   wire        split0;
   wire        en0;
   wire        en1;
   wire        tick0;
   wire        tick1;
   wire        tick_hi_split;
   wire [16:0] step0;
   wire [16:0] step1;
   wire [8:0]  low_split_sum;
   wire [8:0]  high_split_sum;
   wire        setup;
   wire        access;
   wire [7:0]  wr_sel;
   wire        wr;
   reg  [7:0]  rd_byte;
   reg  [7:0]  low0_nxt;
   reg  [7:0]  high0_nxt;
   reg  [7:0]  low1_nxt;
   reg  [7:0]  high1_nxt;
   reg         ovf0;
   reg         ovf1;
   reg         ovf_hi_split;
   reg         flag0_set;
   reg         flag1_set;

   // ****************************************
   // Functions
   // ****************************************
   // Register index decode: index when word aligned and mapped, else zero
   function [7:0] reg_index;
      input [11:0] addr;
      begin
         reg_index = 8'h00;
         if (addr[1:0] == 2'b00) begin
            case (addr[9:2])
               `IDX_CTRL, `IDX_MODE, `IDX_AUX,
               `IDX_LOW0, `IDX_LOW1, `IDX_HIGH0, `IDX_HIGH1: reg_index = addr[9:2];
               default: reg_index = 8'h00;
            endcase
            if (addr[11:10] != 2'b00) begin
               reg_index = 8'h00;
            end
         end
      end
   endfunction

   // One count step: {overflow, high byte, low byte}
   function [16:0] count_step;
      input [1:0] mode;
      input [7:0] lo;
      input [7:0] hi;
      reg   [16:0] sum;
      begin
         sum = 17'h00000;
         case (mode)
            `MODE_13BIT: begin
               // 13-bit count; upper three low bits are left untouched
               if (lo[4:0] == 5'h1f) begin
                  sum = {1'b0, hi, 8'h00} + 17'h00100;
                  count_step = {sum[16], sum[15:8], lo[7:5], 5'h00};
               end else begin
                  count_step = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
               end
            end
            `MODE_16BIT: begin
               sum = {1'b0, hi, lo} + 17'h00001;
               count_step = sum;
            end
            `MODE_RELOAD: begin
               if (lo == 8'hff) begin
                  count_step = {1'b1, hi, hi};
               end else begin
                  count_step = {1'b0, hi, lo + 8'h01};
               end
            end
            default: begin
               count_step = {1'b0, hi, lo};
            end
         endcase
      end
   endfunction

   // ****************************************
   // Pin conditioning and prescaler
   // ****************************************
   pin_filter u_ev0 (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .pin_in  (timer0_event_pin),
      .level_r (ev0_lvl),
      .fall_r  (ev0_fall)
   );
   pin_filter u_ev1 (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .pin_in  (timer1_event_pin),
      .level_r (ev1_lvl),
      .fall_r  (ev1_fall)
   );
   pin_filter u_gate0 (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .pin_in  (timer0_gate_pin),
      .level_r (gate0_lvl),
      .fall_r  (gate0_fall)
   );
   pin_filter u_gate1 (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .pin_in  (timer1_gate_pin),
      .level_r (gate1_lvl),
      .fall_r  (gate1_fall)
   );
   prescale_tick #(
      .DIVIDE (`SLOW_DIVIDE)
   ) u_div (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .tick_r  (slow_tick)
   );

   // ****************************************
   // Count enables and tick sources
   // ****************************************
   assign nib0   = timer_mode_select_r[3:0];
   assign nib1   = timer_mode_select_r[`MODE_T1_SHIFT+3:`MODE_T1_SHIFT];
   assign mode0  = {nib0[`NIB_MHI], nib0[`NIB_MLO]};
   assign mode1  = {nib1[`NIB_MHI], nib1[`NIB_MLO]};
   assign split0 = (mode0 == `MODE_SPLIT);
   // Run bit enables counting, and the gate pin must also be high when the gate bit is set
   assign en0 = timer0_run_r && (!nib0[`NIB_GATE] || gate0_lvl);
   assign en1 = timer1_run_r && (!nib1[`NIB_GATE] || gate1_lvl);
   // Event fall in counter function, clock in timer function
   assign tick0 = nib0[`NIB_SRC] ? ev0_fall :
                  (auxiliary_control_two_r[`AUX_FAST0] ? 1'b1 : slow_tick);
   assign tick1 = nib1[`NIB_SRC] ? ev1_fall :
                  (auxiliary_control_two_r[`AUX_FAST1] ? 1'b1 : slow_tick);
   // Split high byte counts machine cycles on the timer 1 run bit
   assign tick_hi_split = slow_tick && timer1_run_r;
   assign step0 = count_step(mode0, timer0_count_low_r, timer0_count_high_r);
   assign step1 = count_step(mode1, timer1_count_low_r, timer1_count_high_r);
   assign low_split_sum  = {1'b0, timer0_count_low_r} + 9'h001;
   assign high_split_sum = {1'b0, timer0_count_high_r} + 9'h001;

   // ****************************************
   // APB decode
   // ****************************************
   assign setup  = psel && !penable;
   assign access = psel && penable && pready;
   assign wr_sel = reg_index(paddr);
   assign wr     = access && pwrite && (wr_sel != 8'h00);

   // ****************************************
   // Next count values
   // ****************************************
   // Counting first, then a software write of the same byte overrides it
   always @* begin
      low0_nxt     = timer0_count_low_r;
      high0_nxt    = timer0_count_high_r;
      low1_nxt     = timer1_count_low_r;
      high1_nxt    = timer1_count_high_r;
      ovf0         = 1'b0;
      ovf1         = 1'b0;
      ovf_hi_split = 1'b0;
      if (split0) begin
         // Two separate 8-bit counters
         if (en0 && tick0) begin
            low0_nxt = low_split_sum[7:0];
            ovf0     = low_split_sum[8];
         end
         if (tick_hi_split) begin
            high0_nxt    = high_split_sum[7:0];
            ovf_hi_split = high_split_sum[8];
         end
      end else if (en0 && tick0) begin
         low0_nxt  = step0[7:0];
         high0_nxt = step0[15:8];
         ovf0      = step0[16];
      end
      // Timer 1 keeps counting for the baud source even when split
      if (en1 && tick1) begin
         low1_nxt  = step1[7:0];
         high1_nxt = step1[15:8];
         ovf1      = step1[16];
      end
      if (wr && wr_sel == `IDX_LOW0) begin
         low0_nxt = pwdata[7:0];
      end
      if (wr && wr_sel == `IDX_HIGH0) begin
         high0_nxt = pwdata[7:0];
      end
      if (wr && wr_sel == `IDX_LOW1) begin
         low1_nxt = pwdata[7:0];
      end
      if (wr && wr_sel == `IDX_HIGH1) begin
         high1_nxt = pwdata[7:0];
      end
      flag0_set = ovf0;
      // While split the timer 1 flag belongs to the timer 0 high byte
      flag1_set = split0 ? ovf_hi_split : ovf1;
   end

   // ****************************************
   // Read multiplexer
   // ****************************************
   always @* begin
      case (wr_sel)
         `IDX_CTRL:  rd_byte = {timer1_overflow_flag_r, timer1_run_r,
                                timer0_overflow_flag_r, timer0_run_r, 4'h0};
         `IDX_MODE:  rd_byte = timer_mode_select_r;
         `IDX_AUX:   rd_byte = auxiliary_control_two_r;
         `IDX_LOW0:  rd_byte = timer0_count_low_r;
         `IDX_HIGH0: rd_byte = timer0_count_high_r;
         `IDX_LOW1:  rd_byte = timer1_count_low_r;
         `IDX_HIGH1: rd_byte = timer1_count_high_r;
         default:    rd_byte = 8'h00;
      endcase
   end

   // ****************************************
   // APB answer: ready one cycle after setup
   // ****************************************
   always @(posedge sys_clk) begin
      if (!rstn) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         if (setup) begin
            prdata  <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
            pslverr <= (wr_sel == 8'h00);
         end else begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
         end
      end
   end

   // ****************************************
   // Registers and counters
   // ****************************************
   always @(posedge sys_clk) begin
      if (!rstn) begin
         timer0_count_low_r      <= `RESET_BYTE;
         timer0_count_high_r     <= `RESET_BYTE;
         timer1_count_low_r      <= `RESET_BYTE;
         timer1_count_high_r     <= `RESET_BYTE;
         timer_mode_select_r     <= `RESET_BYTE;
         auxiliary_control_two_r <= `RESET_BYTE;
         timer0_run_r            <= 1'b0;
         timer1_run_r            <= 1'b0;
         timer0_overflow_flag_r  <= 1'b0;
         timer1_overflow_flag_r  <= 1'b0;
      end else begin
         // Run bits touch only themselves, never the count bytes
         timer0_count_low_r  <= low0_nxt;
         timer0_count_high_r <= high0_nxt;
         timer1_count_low_r  <= low1_nxt;
         timer1_count_high_r <= high1_nxt;
         if (wr && wr_sel == `IDX_MODE) begin
            timer_mode_select_r <= pwdata[7:0];
         end
         if (wr && wr_sel == `IDX_AUX) begin
            auxiliary_control_two_r <= pwdata[7:0];
         end
         if (wr && wr_sel == `IDX_CTRL) begin
            timer0_run_r <= pwdata[`CTRL_RUN0];
            timer1_run_r <= pwdata[`CTRL_RUN1];
         end
         // Set wins over vector clear and over a software write
         if (flag0_set) begin
            timer0_overflow_flag_r <= 1'b1;
         end else if (timer0_vector_ack) begin
            timer0_overflow_flag_r <= 1'b0;
         end else if (wr && wr_sel == `IDX_CTRL) begin
            timer0_overflow_flag_r <= pwdata[`CTRL_FLAG0];
         end
         if (flag1_set) begin
            timer1_overflow_flag_r <= 1'b1;
         end else if (timer1_vector_ack) begin
            timer1_overflow_flag_r <= 1'b0;
         end else if (wr && wr_sel == `IDX_CTRL) begin
            timer1_overflow_flag_r <= pwdata[`CTRL_FLAG1];
         end
      end
   end

   // ****************************************
   // Clock-out and baud pulse
   // ****************************************
   // Clock-out toggles on each timer 0 overflow, giving an even duty cycle
   always @(posedge sys_clk) begin
      if (!rstn) begin
         timer0_clockout_pin   <= 1'b0;
         timer0_clockout_oe    <= 1'b0;
         timer1_overflow_pulse <= 1'b0;
      end else begin
         timer0_clockout_oe <= auxiliary_control_two_r[`AUX_CKOE];
         if (!auxiliary_control_two_r[`AUX_CKOE]) begin
            timer0_clockout_pin <= 1'b0;
         end else if (ovf0) begin
            timer0_clockout_pin <= !timer0_clockout_pin;
         end
         timer1_overflow_pulse <= ovf1;
      end
   end
endmodule // dual_timer_top

/* File: bench/dual_timer_checker.sv */
// Port-level assertions for the dual timer block
`timescale 1ns/1ps
`include "timer_consts.vh"
module dual_timer_checker (
   // Clock and reset
   input logic        sys_clk,
   input logic        rstn,
   // Register bus
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   // Board pins
   input logic        timer0_event_pin,
   input logic        timer1_event_pin,
   input logic        timer0_gate_pin,
   input logic        timer1_gate_pin,
   input logic        timer0_vector_ack,
   input logic        timer1_vector_ack,
   // Outputs
   input logic        timer0_clockout_pin,
   input logic        timer0_clockout_oe,
   input logic        timer1_overflow_pulse
);
   // ****************************************
   // Address decode and run shadow
   // ****************************************
   wire [7:0] idx    = paddr[9:2];
   wire       wd0    = pwdata[0];
   wire       wr_acc = psel && penable && pready && pwrite;
   wire       mapped = paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00 && (idx == `IDX_CTRL ||
      idx == `IDX_MODE || idx == `IDX_LOW0 || idx == `IDX_LOW1 || idx == `IDX_HIGH0 ||
      idx == `IDX_HIGH1 || idx == `IDX_AUX);
   logic      run1_r;
   // Last run bit software wrote for timer 1
   always @(posedge sys_clk) begin
      if (!rstn) run1_r <= 1'b0;
      else if (wr_acc && mapped && idx == `IDX_CTRL) run1_r <= pwdata[6];
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // ****************************************
   // Assertions
   // ****************************************
   property p_rdy_setup; psel && !penable |=> pready; endproperty
   a_rdy_setup: assert property (p_rdy_setup) else $error("no answer");
   property p_rdy_one; pready |=> !pready; endproperty
   a_rdy_one: assert property (p_rdy_one) else $error("answer too long");
   property p_err_map; psel && !penable |=> pslverr == !$past(mapped); endproperty
   a_err_map: assert property (p_err_map) else $error("error flag wrong");
   property p_err_rdy; pslverr |-> pready; endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
   property p_idle_data; !pready |-> prdata == 32'h0; endproperty
   a_idle_data: assert property (p_idle_data) else $error("stray read data");
   property p_upper_zero; pready |-> prdata[31:8] == 24'h0; endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper data set");
   property p_ctrl_low; pready && !pwrite && mapped && idx == `IDX_CTRL |-> prdata[3:0] == 4'h0;
   endproperty
   a_ctrl_low: assert property (p_ctrl_low) else $error("control low bits set");
   property p_oe; wr_acc && mapped && idx == `IDX_AUX |-> ##2 timer0_clockout_oe == $past(wd0, 2);
   endproperty
   a_oe: assert property (p_oe) else $error("clock-out enable wrong");
   property p_pin_oe; $rose(timer0_clockout_pin) |-> timer0_clockout_oe; endproperty
   a_pin_oe: assert property (p_pin_oe) else $error("clock-out while off");
   property p_pulse_run;
      timer1_overflow_pulse |-> run1_r || $past(run1_r) || $past(run1_r, 2);
   endproperty
   a_pulse_run: assert property (p_pulse_run) else $error("overflow while stopped");
endmodule // dual_timer_checker

/* File: bench/board_pins.sv */
// Board-side model of the event and gate pins
`timescale 1ns/1ps
module board_pins (
   // Clock
   input  logic       sys_clk,
   // Pins toward the block
   output logic [1:0] event_pin,
   output logic [1:0] gate_pin
);
   // Event pins rest high, gates closed
   initial begin
      event_pin = 2'b11;
      gate_pin  = 2'b00;
   end
   // Falling edges, each level held h clocks
   task automatic falls(input int t, input int n, input int h);
      repeat (n) begin
         repeat (h) @(posedge sys_clk);
         event_pin[t] <= 1'b0;
         repeat (h) @(posedge sys_clk);
         event_pin[t] <= 1'b1;
      end
      repeat (8) @(posedge sys_clk);
   endtask
   // Gate pin level
   task automatic gate(input int t, input logic v);
      @(posedge sys_clk);
      gate_pin[t] <= v;
   endtask
endmodule // board_pins

/* File: bench/dual_timer_counter_four_mode_test.sv */
// Self-checking bench for the dual four-mode timer block
`timescale 1ns/1ps
`include "timer_consts.vh"
module dual_timer_counter_four_mode_test;
   // ****************************************
   // Signals
   // ****************************************
   logic        sys_clk, rstn, psel, penable, pwrite, ck_pin, ck_oe, t1_pulse, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0]  ev, gt, ack;
   logic [7:0]  q;
   logic        err;
   int          n_fail, compares, cyc, acc_cyc, n_pulse;
   logic [7:0]  regs [0:6] = '{`IDX_CTRL, `IDX_MODE, `IDX_AUX, `IDX_LOW0, `IDX_LOW1,
                                `IDX_HIGH0, `IDX_HIGH1};
   dual_timer_top dut_u (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer0_event_pin(ev[0]), .timer1_event_pin(ev[1]),
      .timer0_gate_pin(gt[0]), .timer1_gate_pin(gt[1]), .timer0_vector_ack(ack[0]),
      .timer1_vector_ack(ack[1]), .timer0_clockout_pin(ck_pin), .timer0_clockout_oe(ck_oe),
      .timer1_overflow_pulse(t1_pulse));
   board_pins bp_u (.sys_clk(sys_clk), .event_pin(ev), .gate_pin(gt));
   // Clock and cycle count
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) cyc <= cyc + 1;
   // Timer 1 overflow pulses seen on the baud output
   always @(posedge sys_clk) n_pulse <= n_pulse + t1_pulse;
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic near(input int v, input int e, input int tol);
      near = v >= e - tol && v <= e + tol;
   endfunction
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One bus transfer, held until ready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1);
      chk("access cycles", n[15:0], 16'h0001);
      q       = prdata[7:0];
      err     = pslverr;
      acc_cyc = cyc;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      apb(1'b1, {2'b00, i, 2'b00}, d);
   endtask
   task automatic rd(input logic [7:0] i);
      apb(1'b0, {2'b00, i, 2'b00}, 8'h00);
   endtask
   // Load one timer, count n falls, judge bytes and flags
   task automatic run_count(input int t, input logic [3:0] nib, input logic [7:0] lo,
      input logic [7:0] hi, input int n, input logic [7:0] e_lo, input logic [7:0] e_hi,
      input logic e_f);
      logic [7:0] run;
      run = t ? 8'h40 : 8'h10;
      wr(`IDX_CTRL, 8'h00);
      wr(`IDX_MODE, t ? {nib, 4'h0} : {4'h0, nib});
      wr(t ? `IDX_LOW1 : `IDX_LOW0, lo);
      wr(t ? `IDX_HIGH1 : `IDX_HIGH0, hi);
      wr(`IDX_CTRL, run);
      bp_u.falls(t, n, 2 + 2 * t);
      rd(t ? `IDX_LOW1 : `IDX_LOW0);
      chk("low byte", q & (nib[1:0] == 2'b00 ? 8'h1f : 8'hff), e_lo);
      rd(t ? `IDX_HIGH1 : `IDX_HIGH0);
      chk("high byte", q, e_hi);
      rd(`IDX_CTRL);
      chk("control", q, run | (e_f ? run << 1 : 8'h00));
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      foreach (regs[i]) begin
         rd(regs[i]);
         chk("reset value", q, 8'h00);
      end
      apb(1'b0, 12'h004, 8'h00);
      chk("unmapped error", err, 1'b1);
      chk("unmapped data", q, 8'h00);
      $display("t_reset done");
   endtask
   task automatic t_rw;
      for (int i = 1; i < 7; i++) begin
         wr(regs[i], regs[i] ^ 8'h3c);
         rd(regs[i]);
         chk("readback", q, regs[i] ^ 8'h3c);
         wr(regs[i], 8'h00);
      end
      wr(`IDX_CTRL, 8'h5f);
      rd(`IDX_CTRL);
      chk("control bits", q, 8'h50);
      wr(`IDX_CTRL, 8'h00);
      $display("t_rw done");
   endtask
   task automatic t_modes;
      for (int t = 0; t < 2; t++) begin
         run_count(t, 4'h5, 8'hfe, 8'hff, 3, 8'h01, 8'h00, 1'b1);
         chk("baud pulses", n_pulse[15:0], t[15:0]);
         @(posedge sys_clk) ack[t] <= 1'b1;
         @(posedge sys_clk) ack[t] <= 1'b0;
         rd(`IDX_CTRL);
         chk("flag after vector", q, t ? 8'h40 : 8'h10);
         run_count(t, 4'h4, 8'hff, 8'hff, 1, 8'h00, 8'h00, 1'b1);
         run_count(t, 4'h6, 8'hfe, 8'hf0, 3, 8'hf1, 8'hf0, 1'b1);
         run_count(t, 4'hd, 8'h10, 8'h00, 3, 8'h10, 8'h00, 1'b0);
         bp_u.gate(t, 1'b1);
         run_count(t, 4'hd, 8'h10, 8'h00, 3, 8'h13, 8'h00, 1'b0);
         bp_u.gate(t, 1'b0);
      end
      run_count(1, 4'h7, 8'h10, 8'h22, 3, 8'h10, 8'h22, 1'b0);
      $display("t_modes done");
   endtask
   task automatic t_split;
      int d;
      wr(`IDX_CTRL, 8'h00);
      wr(`IDX_MODE, 8'h07);
      wr(`IDX_LOW0, 8'h00);
      wr(`IDX_HIGH0, 8'hff);
      wr(`IDX_CTRL, 8'h50);
      d = acc_cyc;
      bp_u.falls(0, 3, 3);
      rd(`IDX_CTRL);
      chk("split flags", q, 8'hd0);
      wr(`IDX_CTRL, 8'h00);
      d = acc_cyc - d;
      rd(`IDX_LOW0);
      chk("split low", q, 8'h03);
      rd(`IDX_HIGH0);
      chk("split high", near(int'(q) + 1, d / 12, 1), 1'b1);
      $display("t_split done");
   endtask
   task automatic t_tick;
      int d;
      for (int f = 0; f < 2; f++) begin
         wr(`IDX_AUX, f ? 8'hc0 : 8'h00);
         wr(`IDX_MODE, 8'h11);
         wr(`IDX_LOW0, 8'h00);
         wr(`IDX_HIGH0, 8'h00);
         wr(`IDX_LOW1, 8'h00);
         wr(`IDX_HIGH1, 8'h00);
         wr(`IDX_CTRL, 8'h50);
         d = acc_cyc;
         repeat (120) @(posedge sys_clk);
         wr(`IDX_CTRL, 8'h00);
         d = acc_cyc - d;
         rd(`IDX_LOW0);
         chk("tick count", near(q, f ? d : d / 12, 1), 1'b1);
         rd(`IDX_LOW1);
         chk("tick count 1", near(q, f ? d : d / 12, 1), 1'b1);
      end
      $display("t_tick done");
   endtask
   task automatic t_clockout;
      int tg, hi;
      logic p;
      wr(`IDX_AUX, 8'h81);
      wr(`IDX_MODE, 8'h02);
      wr(`IDX_HIGH0, 8'hfe);
      wr(`IDX_LOW0, 8'hfe);
      wr(`IDX_CTRL, 8'h10);
      chk("clock-out enable", ck_oe, 1'b1);
      tg = 0;
      hi = 0;
      p = ck_pin;
      repeat (48) begin
         @(posedge sys_clk);
         tg += (ck_pin !== p);
         hi += ck_pin;
         p = ck_pin;
      end
      chk("toggles", near(tg, 24, 1), 1'b1);
      chk("duty", near(hi, 24, 2), 1'b1);
      wr(`IDX_AUX, 8'h00);
      repeat (3) @(posedge sys_clk);
      chk("clock-out off", {ck_oe, ck_pin}, 2'b00);
      wr(`IDX_CTRL, 8'h00);
      $display("t_clockout done");
   endtask
   // ****************************************
   // Verdict, main sequence, watchdog
   // ****************************************
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      cyc = 0;
      n_pulse = 0;
      n_fail = 0;
      compares = 0;
      {rstn, psel, penable, pwrite, paddr, pwdata, ack} = '0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      t_reset;
      t_rw;
      t_modes;
      t_split;
      t_tick;
      t_clockout;
      finish_test;
   end
   // Far beyond the expected thousand or so cycles
   initial begin
      #60000;
      n_fail++;
      finish_test;
   end
endmodule // dual_timer_counter_four_mode_test
bind dual_timer_top dual_timer_checker chk_u (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .timer0_event_pin, .timer1_event_pin, .timer0_gate_pin,
   .timer1_gate_pin, .timer0_vector_ack, .timer1_vector_ack, .timer0_clockout_pin,
   .timer0_clockout_oe, .timer1_overflow_pulse);
